// >>> clkid_assertions.sv
// Purpose: Port timing checks of the ident/count bank
// Assumes: SCL half period at least four clocks
// Notes:   Bound into every bank instance
`timescale 1ns/100ps
module clkid_assertions (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  // Bus pins
  input wire logic       SMB_SCL,
  input wire logic       SMB_SDA_IN,
  input wire logic       SMB_SDA_OUT,
  input wire logic       SMB_SDA_OE,
  // Count
  input wire logic [4:0] READBACK_COUNT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Reset state, checked while reset is held
  AST_RST_VALUES: assert property (disable iff (1'b0) SYS_RST |=>
    READBACK_COUNT == 5'h08 && !SMB_SDA_OE) else $error("reset state wrong");
  AST_OPEN_DRAIN: assert property (SMB_SDA_OUT == 1'b0)
    else $error("sda out not low");
  // Drive moves only just after a sampled SCL fall
  AST_OE_AFTER_FALL: assert property ($changed(SMB_SDA_OE) |-> !SMB_SCL &&
    ($past(SMB_SCL, 2) || $past(SMB_SCL, 3))) else $error("oe moved off fall");
  AST_OE_HOLD: assert property (SMB_SCL && $past(SMB_SCL) |-> $stable(SMB_SDA_OE))
    else $error("oe moved in high");
  AST_OE_SETTLED: assert property ($changed(SMB_SDA_OE) |=> $stable(SMB_SDA_OE) [*4])
    else $error("oe glitch");
  // Count loads in the high half of its last data bit
  AST_CNT_ON_SCL: assert property ($changed(READBACK_COUNT) |-> $past(SMB_SCL) &&
    READBACK_COUNT[0] == $past(SMB_SDA_IN)) else $error("count load wrong");
endmodule
bind clkid_bank clkid_assertions u_chk (
  .CORE_CLK       (CORE_CLK),
  .SYS_RST        (SYS_RST),
  .SMB_SCL        (SMB_SCL),
  .SMB_SDA_IN     (SMB_SDA_IN),
  .SMB_SDA_OUT    (SMB_SDA_OUT),
  .SMB_SDA_OE     (SMB_SDA_OE),
  .READBACK_COUNT (READBACK_COUNT)
);

// >>> clkid_bank.sv
// Purpose: Ident and read-count registers behind an SMBus slave port
// Assumes: Host follows indexed block write/read framing
// Notes:   Indices other than 4 to 7 read zero and ignore writes
`timescale 1ns/100ps
`include "clkid_defines.svh"
module clkid_bank
  import clkid_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR   = 7'h50,   // Bus address, plain default
  parameter logic [3:0] REV_IDENT    = 4'h3,    // Arbitrary value
  parameter logic [3:0] VENDOR_IDENT = 4'h5,    // Arbitrary value
  parameter logic [1:0] CLASS_IDENT  = 2'h2,    // Arbitrary value
  parameter logic [5:0] DEVICE_IDENT = 6'h15    // Arbitrary value
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // SMBus pins, SDA open drain
  input  wire logic       SMB_SCL,
  input  wire logic       SMB_SDA_IN,
  output logic            SMB_SDA_OUT,
  output logic            SMB_SDA_OE,
  // Programmed read length
  output logic [4:0]      READBACK_COUNT
);
  clkid_state_t state_q;      // Transaction phase
  logic [7:0]   idx_q;        // Current byte index
  logic [5:0]   remain_q;     // Data bytes still to send
  logic [4:0]   count_q;      // Programmed read length
  logic         ack_en_q;     // ACK the byte now ending
  logic         tx_en_q;      // Device owns SDA data bits
  logic [7:0]   tx_byte_q;    // Byte being sent
  logic         start_p;
  logic         stop_p;
  logic         byte_done;
  logic [7:0]   rx_byte;
  logic         ack_slot;
  logic         host_ack;

  // Read decode; used for every data byte of a block read
  function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [4:0] cnt);
    logic [7:0] v;
    v = `CLKID_UNMAPPED_VALUE;
    unique case (idx)
      `CLKID_OFF_RESERVED:        v = `CLKID_RESERVED_VALUE;
      `CLKID_OFF_REV_VENDOR:      v = {REV_IDENT, VENDOR_IDENT};
      `CLKID_OFF_CLASS_DEVICE:    v = {CLASS_IDENT, DEVICE_IDENT};
      `CLKID_OFF_READBACK_LENGTH: v = {3'h0, cnt};
      default:                    v = `CLKID_UNMAPPED_VALUE;
    endcase
    return v;
  endfunction

  // Bit engine
  clkid_smb_bit u_bit (
    .clk       (CORE_CLK),
    .rst       (SYS_RST),
    .scl_i     (SMB_SCL),
    .sda_i     (SMB_SDA_IN),
    .sda_oe    (SMB_SDA_OE),
    .start_p   (start_p),
    .stop_p    (stop_p),
    .byte_done (byte_done),
    .rx_byte   (rx_byte),
    .ack_slot  (ack_slot),
    .host_ack  (host_ack),
    .ack_en    (ack_en_q),
    .tx_en     (tx_en_q),
    .tx_byte   (tx_byte_q)
  );

  // Open drain: only ever pulls low
  assign SMB_SDA_OUT    = 1'b0;
  assign READBACK_COUNT = count_q;

  // Transaction sequencer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || stop_p) begin
      state_q <= CLKID_IDLE;
    end else if (start_p) begin
      state_q <= CLKID_ADDR;      // Repeated start lands here too
    end else if (byte_done && !tx_en_q) begin
      unique case (state_q)
        CLKID_ADDR: begin
          if (rx_byte[7:1] != SLAVE_ADDR) begin
            state_q <= CLKID_IGNORE;           // Not ours, stay silent
          end else if (rx_byte[0]) begin
            state_q <= CLKID_RSTART;
          end else begin
            state_q <= CLKID_CMD;
          end
        end
        CLKID_CMD:    state_q <= CLKID_WCOUNT;
        CLKID_WCOUNT: state_q <= CLKID_WDATA;
        default:      state_q <= state_q;
      endcase
    end else if (ack_slot) begin
      if (state_q == CLKID_RSTART) begin
        state_q <= CLKID_RSEND;
      end else if (state_q == CLKID_RSEND && (!host_ack || remain_q == 6'h00)) begin
        state_q <= CLKID_IGNORE;               // NACK or count exhausted
      end
    end
  end

  // ACK decision for each received byte, dropped after the slot
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || stop_p || start_p || ack_slot) begin
      ack_en_q <= 1'b0;
    end else if (byte_done && !tx_en_q) begin
      unique case (state_q)
        CLKID_ADDR:   ack_en_q <= (rx_byte[7:1] == SLAVE_ADDR);
        CLKID_CMD,
        CLKID_WCOUNT,
        CLKID_WDATA:  ack_en_q <= 1'b1;
        default:      ack_en_q <= 1'b0;
      endcase
    end
  end

  // Index: set by command byte, advanced per data byte
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      idx_q <= 8'h00;
    end else if (byte_done && !tx_en_q && state_q == CLKID_CMD) begin
      idx_q <= rx_byte;
    end else if (byte_done && !tx_en_q && state_q == CLKID_WDATA) begin
      idx_q <= idx_q + 8'h01;
    end else if (ack_slot && state_q == CLKID_RSEND && host_ack && remain_q != 6'h00) begin
      idx_q <= idx_q + 8'h01;
    end
  end

  // Transmit path: count first, then consecutive bytes
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || stop_p || start_p) begin
      tx_en_q   <= 1'b0;
      tx_byte_q <= 8'hff;
      remain_q  <= 6'h00;
    end else if (ack_slot && state_q == CLKID_RSTART) begin
      tx_en_q   <= 1'b1;
      tx_byte_q <= {3'h0, count_q};
      remain_q  <= {1'b0, count_q};
    end else if (ack_slot && state_q == CLKID_RSEND) begin
      if (host_ack && remain_q != 6'h00) begin
        tx_byte_q <= rd_byte(idx_q, count_q);
        remain_q  <= remain_q - 6'h01;
      end else begin
        tx_en_q   <= 1'b0;                               // Release SDA for stop
        tx_byte_q <= 8'hff;
      end
    end
  end

  // Length register; only the count field is writable
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      count_q <= `CLKID_READBACK_COUNT_RST;
    end else if (byte_done && !tx_en_q && state_q == CLKID_WDATA
                 && idx_q == `CLKID_OFF_READBACK_LENGTH) begin
      // Upper three bits dropped, they stay reserved
      count_q <= rx_byte[`CLKID_READBACK_COUNT_MSB:`CLKID_READBACK_COUNT_LSB];
    end
  end
endmodule

// >>> clkid_bank_tb.sv
// Purpose: Self-checking bench of the ident/count bank
// Assumes: Default identity parameters of the bank
// Notes:   Random data from an xorshift seeded at 51
`timescale 1ns/100ps
module clkid_bank_tb;
  logic        clk;      // Core clock
  logic        rst;      // Synchronous reset
  logic        scl;      // Bus clock from host
  logic        sda;      // Resolved data wire
  logic        oe;       // Device pull-down
  logic [4:0]  cnt;      // Programmed count
  logic [31:0] seed;     // Random state
  logic [7:0]  v;        // Random byte
  int          errors;   // Mismatches
  int          n_tests;  // Comparisons
  clkid_bank dut (.CORE_CLK(clk), .SYS_RST(rst), .SMB_SCL(scl), .SMB_SDA_IN(sda),
    .SMB_SDA_OUT(), .SMB_SDA_OE(oe), .READBACK_COUNT(cnt));
  clkid_host h (.clk(clk), .sda_oe(oe), .scl(scl), .sda(sda));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Xorshift step
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected read value of an index
  function automatic logic [7:0] exp_b(input logic [7:0] i, input logic [4:0] c);
    case (i)
      8'h05:   return {4'h3, 4'h5};
      8'h06:   return {2'h2, 6'h15};
      8'h07:   return {3'h0, c};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Indexed block write of one data byte
  task automatic wreg(input logic [6:0] a, input logic [7:0] i, d, input logic ea);
    logic k;
    h.host_start();
    h.host_wr({a, 1'b0}, k);
    chk("addr_ack", {7'h0, k}, {7'h0, ea});
    h.host_wr(i, k);
    h.host_wr(8'h01, k);
    h.host_wr(d, k);
    h.host_stop();
  endtask
  // Indexed block read of c bytes
  task automatic rblk(input logic [7:0] i, input logic [4:0] c);
    logic k;
    logic [7:0] d;
    h.host_start();
    h.host_wr(8'ha0, k);
    h.host_wr(i, k);
    h.host_start();
    h.host_wr(8'ha1, k);
    h.host_rd(c != 5'h00, d);
    chk("count_byte", d, {3'h0, c});
    for (int j = 0; j < c; j++) begin
      h.host_rd(j < c - 1, d);
      chk("data", d, exp_b(i + j[7:0], c));
    end
    h.host_stop();
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    errors = 0;
    n_tests = 0;
    seed = 32'd51;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk("count_rst", {3'h0, cnt}, 8'h08);
    rblk(8'h04, 5'h08);
    // Writes to read-only and reserved bytes change nothing
    for (int n = 4; n < 7; n++) wreg(7'h50, n[7:0], 8'(rnd()), 1'b1);
    for (int n = 0; n < 3; n++) begin
      v = 8'(rnd());
      wreg(7'h50, 8'h07, v, 1'b1);
      chk("count", {3'h0, cnt}, {3'h0, v[4:0]});
      rblk(8'h04 + n[7:0], v[4:0]);
    end
    // Foreign address is ignored
    wreg(7'h51, 8'h07, 8'h00, 1'b0);
    chk("count_kept", {3'h0, cnt}, {3'h0, v[4:0]});
    // Reserved top bits written high must read back zero
    wreg(7'h50, 8'h07, 8'he3, 1'b1);
    rblk(8'h07, 5'h03);
    wreg(7'h50, 8'h07, 8'he0, 1'b1);
    rblk(8'h07, 5'h00);
    // Reset in mid-run restores eight
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk("count_rerst", {3'h0, cnt}, 8'h08);
    end_of_test();
  end
endmodule

// >>> clkid_defines.svh
// Purpose: Offsets, field positions and reset values of the ident/count bank
// Assumes: Byte indices arrive over the SMBus command byte
// Notes:   Identity values are module parameters, not defines
// Function
// - Byte 5 reads revision high, vendor low
// - Byte 6 reads class high, device low
// - Byte 7 bits 4:0 set read count
// - Read count resets to eight
// - Block read sends count, then indexed bytes
`ifndef CLKID_DEFINES_SVH
`define CLKID_DEFINES_SVH

// Register indices
`define CLKID_OFF_RESERVED        8'h04
`define CLKID_OFF_REV_VENDOR      8'h05
`define CLKID_OFF_CLASS_DEVICE    8'h06
`define CLKID_OFF_READBACK_LENGTH 8'h07

// Count field position inside the length byte
`define CLKID_READBACK_COUNT_MSB  4
`define CLKID_READBACK_COUNT_LSB  0

// Reset and reserved values
`define CLKID_READBACK_COUNT_RST  5'h08
`define CLKID_RESERVED_VALUE      8'h00
`define CLKID_UNMAPPED_VALUE      8'h00

// Serial framing
`define CLKID_ACK_SLOT            4'h8
`define CLKID_LAST_DATA_BIT       4'h7

`endif

// >>> clkid_host.sv
// Purpose: SMBus host model driving the bank's pins
// Assumes: SDA pulled up; half bit period of five clocks
// Notes:   Released SDA reads one through the pull-up
`timescale 1ns/100ps
module clkid_host (
  // Clock
  input  wire logic clk,
  // Bus
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_h;  // Host drive, one = released
  // Wired-AND of host and device
  assign sda = sda_h & ~sda_oe;
  // Bus idles high
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // Half period, then step off the edge
  task automatic hp();
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Start or repeated start
  task automatic host_start();
    sda_h = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_h = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  // Stop, SDA rises while SCL high
  task automatic host_stop();
    sda_h = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_h = 1'b1;
    hp();
  endtask
  // One bit, SDA set while SCL low
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask
  // Byte out MSB first, ack seen low
  task automatic host_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in MSB first, then ack or nack
  task automatic host_rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule

// >>> clkid_pkg.sv
// Purpose: Shared types of the ident/count bank
// Assumes: Nothing beyond the defines header
// Notes:   Only the transaction state type lives here
package clkid_pkg;

  // Transaction phase, advanced byte by byte
  typedef enum logic [2:0] {
    CLKID_IDLE    = 3'b000,
    CLKID_ADDR    = 3'b001,
    CLKID_CMD     = 3'b010,
    CLKID_WCOUNT  = 3'b011,
    CLKID_WDATA   = 3'b100,
    CLKID_RSTART  = 3'b101,
    CLKID_RSEND   = 3'b110,
    CLKID_IGNORE  = 3'b111
  } clkid_state_t;

endpackage

// >>> clkid_smb_bit.sv
// Purpose: Bit level SMBus slave engine: framing, shifting, ACK drive
// Assumes: SCL and SDA are synchronous to the core clock and far slower
// Notes:   Byte and ack-slot events are one-cycle pulses on SCL rise
`timescale 1ns/100ps
module clkid_smb_bit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe,
  // Framing events
  output logic            start_p,
  output logic            stop_p,
  output logic            byte_done,
  output logic [7:0]      rx_byte,
  output logic            ack_slot,
  output logic            host_ack,
  // Controls from the sequencer
  input  wire logic       ack_en,
  input  wire logic       tx_en,
  input  wire logic [7:0] tx_byte
);
  logic       scl_q;        // Previous SCL sample
  logic       sda_q;        // Previous SDA sample
  logic [3:0] cnt_q;        // SCL rises in this 9-bit frame
  logic [7:0] shift_q;      // Received bits, MSB first
  logic       sda_oe_q;     // Pulling SDA low
  logic       scl_rise;
  logic       scl_fall;

  assign scl_rise  = scl_i & ~scl_q;
  assign scl_fall  = ~scl_i & scl_q;
  // Start and stop: SDA moves while SCL stays high
  assign start_p   = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_p    = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_done = scl_rise & (cnt_q == `CLKID_LAST_DATA_BIT);
  assign ack_slot  = scl_rise & (cnt_q == `CLKID_ACK_SLOT);
  assign host_ack  = ~sda_i;
  assign rx_byte   = {shift_q[6:0], sda_i};
  assign sda_oe    = sda_oe_q;

  // Pin history for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Bit counter and shifter; a start realigns the frame
  always_ff @(posedge clk) begin
    if (rst || start_p || stop_p) begin
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (scl_rise) begin
      shift_q <= {shift_q[6:0], sda_i};
      cnt_q   <= (cnt_q == `CLKID_ACK_SLOT) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // SDA changes only while SCL is low, so no false start/stop
  always_ff @(posedge clk) begin
    if (rst || start_p || stop_p) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_q == `CLKID_ACK_SLOT) begin
        sda_oe_q <= ack_en & ~tx_en;                  // Our ACK bit
      end else if (tx_en && cnt_q < `CLKID_ACK_SLOT) begin
        sda_oe_q <= ~tx_byte[3'(4'h7 - cnt_q)];       // Data bit, MSB first
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end
endmodule
